//--- ccs_pkg.sv
// Constants, types and helpers shared by the clock source select logic
package ccs_pkg;

	// ----------------------------------------------------------------
	// Register map (APB byte addresses)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W   = 8;
	localparam logic [7:0]  CSS_OFS   = 8'h00;
	localparam logic [7:0]  WPROT_OFS = 8'h04;
	localparam logic [7:0]  STAT_OFS  = 8'h08;

	// ----------------------------------------------------------------
	// Clock source select field positions and reset value
	// ----------------------------------------------------------------
	localparam int unsigned BIT_SYSPLL  = 7;
	localparam int unsigned BIT_OSCKEEP = 6;
	localparam int unsigned BIT_WSDIS   = 5;
	localparam int unsigned BIT_WSEL_HI = 4;
	localparam int unsigned BIT_PRE     = 3;
	localparam int unsigned BIT_WLSTOP  = 2;
	localparam int unsigned BIT_TSEL    = 1;
	localparam int unsigned BIT_WSEL_LO = 0;
	localparam logic [7:0]  CSS_RST     = 8'h80;

	// Protect and status fields
	localparam int unsigned BIT_WPROT   = 0;
	localparam logic        WPROT_RST   = 1'b0;
	localparam int unsigned STAT_OSCQ   = 0;
	localparam int unsigned STAT_STOP   = 1;
	localparam int unsigned STAT_FULL   = 2;
	localparam int unsigned STAT_WLOCK  = 3;
	localparam int unsigned STAT_STALL  = 4;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CORE_HZ   = 20_000_000;
	localparam int unsigned ACLK_HZ   = 1_000_000;
	localparam int unsigned ACLK_DIV  = CORE_HZ / ACLK_HZ;
	localparam int unsigned ACLK_CW   = 5;
	// Gate sync stages plus phase uncertainty stay within 4 aux cycles
	localparam int unsigned WSTOP_LAT = 4;
	localparam int unsigned WSTOP_SYN = WSTOP_LAT / 2;

	// ----------------------------------------------------------------
	// Types and helpers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CCS_WSRC_IRC  = 2'b00,
		CCS_WSRC_OSC  = 2'b01,
		CCS_WSRC_ACLK = 2'b10
	} ccs_wsrc_t;

	typedef enum logic [1:0] {
		CCS_ST_RUN    = 2'b00,
		CCS_ST_PSEUDO = 2'b01,
		CCS_ST_FULL   = 2'b10
	} ccs_stop_t;

	function automatic ccs_wsrc_t ccs_wsrc(input logic hi, input logic lo);
		ccs_wsrc = hi ? CCS_WSRC_ACLK : (lo ? CCS_WSRC_OSC : CCS_WSRC_IRC);
	endfunction

endpackage

//--- ccs_sync.sv
// Two flip-flop level synchroniser for one asynchronous input
`timescale 1ns/1ns
module ccs_sync (
	input  wire logic core_clk_i,
	input  wire logic nrst_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic meta_r;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_r <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule

//--- ccs_aclk_div.sv
// Divider that makes the auxiliary RC clock as a one-cycle enable
`timescale 1ns/1ns
module ccs_aclk_div
	import ccs_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic nrst_i,
	output logic      aclk_en_o
);
	localparam logic [ACLK_CW-1:0] LAST = ACLK_CW'(ACLK_DIV - 1);
	logic [ACLK_CW-1:0] cnt_r;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_r     <= '0;
			aclk_en_o <= 1'b0;
		end else begin
			aclk_en_o <= (cnt_r == LAST);
			cnt_r     <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
		end
	end
endmodule

//--- ccs_clk_sel.sv
// Clock source select register with APB access and stop-mode clock control
//
// Overview of operation
// R1 - Bit 7 picks PLL or qualified oscillator as system clock source.
// R2 - Clearing the PLL select is accepted only while oscillator is qualified.
// R3 - Oscillator loss or full stop entry forces PLL select to one.
// R4 - Bit 6 keeps the oscillator running in stop (pseudo stop).
// R5 - Software waits oscillator start-up time before requesting pseudo stop.
// R6 - Stop clock disable freezes watchdog aux clock during stop.
// R7 - Aux-clocked watchdog stop entry and exit lag at most 4 aux cycles.
// R8 - Software avoids stop requests for 2 aux cycles after stop exit.
// R9 - Stop clock disable never gates the autonomous timer aux clock.
// R10 - High select picks aux clock, else low select picks RC or oscillator.
// R11 - With high select set, low select changes do nothing.
// R12 - Any change of high select restarts the watchdog period.
// R13 - High select settable anytime and untouched by oscillator loss.
// R14 - Tick runs in pseudo stop only with bit 3 and tick select set.
// R15 - Watchdog runs in pseudo stop only with bit 2 and oscillator source; the code also runs it on aux source with bit 5 clear.
// R16 - Bit 1 picks tick clock; any change restarts tick period.
// R17 - Tick select set only while qualified; cleared on oscillator loss.
// R18 - Low select picks watchdog RC or oscillator; change restarts period.
// R19 - Low select set only while qualified; cleared on oscillator loss.
// R20 - Software reads the register back after writing it.
// R21 - Oscillator loss on oscillator system clock stalls unless monitor reset.
// R22 - All writes ignored while the write protect bit is set; the write protect register itself stays writable.
// R23 - Normal mode locks watchdog bits after watchdog control write.
// R24 - Automatic forcing wins over a simultaneous software write.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
module ccs_clk_sel
	import ccs_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              nrst_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic              osc_qualified_i,
	input  wire logic              stop_req_i,
	input  wire logic              special_mode_i,
	input  wire logic              wdog_ctrl_written_i,
	input  wire logic              osc_monitor_reset_enable_i,
	output logic                   sys_clk_pll_sel_o,
	output logic                   osc_run_o,
	output logic                   tick_clk_osc_sel_o,
	output logic                   tick_run_o,
	output logic                   tick_restart_o,
	output ccs_wsrc_t              wdog_clk_src_o,
	output logic                   wdog_run_o,
	output logic                   wdog_restart_o,
	output logic                   wdog_aclk_en_o,
	output logic                   atmr_aclk_en_o,
	output logic                   osc_monitor_reset_o,
	output logic                   sys_stall_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic            oscq;
	logic            oscq_d_r;
	logic            aclk_en;
	logic            syspll_r;
	logic            osckeep_r;
	logic            wsdis_r;
	logic            whi_r;
	logic            pre_r;
	logic            wlstop_r;
	logic            tsel_r;
	logic            wlo_r;
	logic            whi_d_r;
	logic            wlo_d_r;
	logic            tsel_d_r;
	logic            wprot_r;
	logic            wonce_r;
	logic            stall_r;
	ccs_stop_t       st_r;
	logic [WSTOP_SYN-1:0] wstop_r;
	logic            setup;
	logic            done;
	logic            hit;
	logic            wr_css;
	logic            wr_wprot;
	logic            wlock;
	logic            osc_lost;
	logic            full_entry;
	logic            in_stop;
	logic            wgate;
	logic [7:0]      css;
	logic [7:0]      wd;
	logic [7:0]      stat;
	ccs_wsrc_t       wsrc;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	ccs_sync u_osc_sync (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.async_i    (osc_qualified_i),
		.sync_o     (oscq)
	);

	ccs_aclk_div u_aclk_div (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.aclk_en_o  (aclk_en)
	);

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// One wait state: read data and error are registered while pready is low
	assign setup   = psel_i & penable_i & ~pready_o;
	assign done    = psel_i & penable_i & pready_o;
	assign wd      = pwdata_i[7:0];
	assign hit     = (paddr_i == CSS_OFS) | (paddr_i == WPROT_OFS) |
	                 (paddr_i == STAT_OFS);
	assign wr_css  = done & pwrite_i & (paddr_i == CSS_OFS) & ~wprot_r; // R22
	assign wr_wprot = done & pwrite_i & (paddr_i == WPROT_OFS);
	assign wlock   = ~special_mode_i & wonce_r; // R23

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= setup;
			pslverr_o <= setup & ~hit;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prdata_o <= '0;
		end else if (setup) begin
			case (paddr_i)
				CSS_OFS:  prdata_o <= {24'h000000, css}; // R20
				WPROT_OFS: prdata_o <= {31'h00000000, wprot_r};
				STAT_OFS: prdata_o <= {24'h000000, stat};
				default:  prdata_o <= '0;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wprot_r <= WPROT_RST;
		end else if (wr_wprot) begin
			wprot_r <= pwdata_i[BIT_WPROT];
		end
	end

	// Watchdog control write-once seen; only reset clears it, and special mode masks the lock
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wonce_r <= 1'b0;
		end else if (wdog_ctrl_written_i) begin
			wonce_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Register image
	// ----------------------------------------------------------------
	always_comb begin
		css              = 8'h00;
		css[BIT_SYSPLL]  = syspll_r;
		css[BIT_OSCKEEP] = osckeep_r;
		css[BIT_WSDIS]   = wsdis_r;
		css[BIT_WSEL_HI] = whi_r;
		css[BIT_PRE]     = pre_r;
		css[BIT_WLSTOP]  = wlstop_r;
		css[BIT_TSEL]    = tsel_r;
		css[BIT_WSEL_LO] = wlo_r;
	end

	always_comb begin
		stat             = 8'h00;
		stat[STAT_OSCQ]  = oscq;
		stat[STAT_STOP]  = in_stop;
		stat[STAT_FULL]  = (st_r == CCS_ST_FULL);
		stat[STAT_WLOCK] = wlock;
		stat[STAT_STALL] = stall_r;
	end

	// ----------------------------------------------------------------
	// Stop mode tracking
	// ----------------------------------------------------------------
	assign in_stop    = (st_r != CCS_ST_RUN);
	assign full_entry = (st_r == CCS_ST_RUN) & stop_req_i & ~osckeep_r;
	assign osc_lost   = ~oscq;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= CCS_ST_RUN;
		end else begin
			case (st_r)
				CCS_ST_RUN: begin
					if (stop_req_i) begin
						st_r <= osckeep_r ? CCS_ST_PSEUDO : CCS_ST_FULL; // R4
					end
				end
				CCS_ST_PSEUDO, CCS_ST_FULL: begin
					if (!stop_req_i) begin
						st_r <= CCS_ST_RUN;
					end
				end
				default: st_r <= CCS_ST_RUN;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Select bits
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			syspll_r <= CSS_RST[BIT_SYSPLL];
		end else if (osc_lost | full_entry) begin
			syspll_r <= 1'b1; // R3 R24
		end else if (wr_css) begin
			if (wd[BIT_SYSPLL]) begin
				syspll_r <= 1'b1; // R1
			end else if (oscq) begin
				syspll_r <= 1'b0; // R2
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			osckeep_r <= CSS_RST[BIT_OSCKEEP];
			pre_r     <= CSS_RST[BIT_PRE];
			wlstop_r  <= CSS_RST[BIT_WLSTOP];
		end else if (wr_css) begin
			osckeep_r <= wd[BIT_OSCKEEP];
			pre_r     <= wd[BIT_PRE];
			wlstop_r  <= wd[BIT_WLSTOP];
		end
	end

	// High select ignores oscillator state on purpose
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wsdis_r <= CSS_RST[BIT_WSDIS];
			whi_r   <= CSS_RST[BIT_WSEL_HI];
		end else if (wr_css & ~wlock) begin
			wsdis_r <= wd[BIT_WSDIS]; // R6
			whi_r  <= wd[BIT_WSEL_HI]; // R13
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tsel_r <= CSS_RST[BIT_TSEL];
		end else if (osc_lost | full_entry) begin
			tsel_r <= 1'b0; // R17 R24
		end else if (wr_css & (oscq | ~wd[BIT_TSEL])) begin
			tsel_r <= wd[BIT_TSEL]; // R16 R17
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wlo_r <= CSS_RST[BIT_WSEL_LO];
		end else if (osc_lost | full_entry) begin
			wlo_r <= 1'b0; // R19 R24
		end else if (wr_css & ~wlock & (oscq | ~wd[BIT_WSEL_LO])) begin
			wlo_r <= wd[BIT_WSEL_LO]; // R18 R19
		end
	end

	// ----------------------------------------------------------------
	// Period restarts
	// ----------------------------------------------------------------
	// Compare against last cycle's copy; restart pulses lag the change by one
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			whi_d_r  <= CSS_RST[BIT_WSEL_HI];
			wlo_d_r  <= CSS_RST[BIT_WSEL_LO];
			tsel_d_r <= CSS_RST[BIT_TSEL];
		end else begin
			whi_d_r  <= whi_r;
			wlo_d_r  <= wlo_r;
			tsel_d_r <= tsel_r;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tick_restart_o <= 1'b0;
			wdog_restart_o <= 1'b0;
		end else begin
			tick_restart_o <= tsel_r ^ tsel_d_r; // R16
			wdog_restart_o <= (whi_r ^ whi_d_r) | // R12
			                  ((wlo_r ^ wlo_d_r) & ~whi_r & ~whi_d_r); // R11 R18
		end
	end

	// ----------------------------------------------------------------
	// Clock selects and run enables
	// ----------------------------------------------------------------
	assign wsrc = ccs_wsrc(whi_r, wlo_r); // R10 R11

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sys_clk_pll_sel_o  <= CSS_RST[BIT_SYSPLL];
			tick_clk_osc_sel_o <= CSS_RST[BIT_TSEL];
			wdog_clk_src_o     <= CCS_WSRC_IRC;
		end else begin
			sys_clk_pll_sel_o  <= syspll_r; // R1
			tick_clk_osc_sel_o <= tsel_r; // R16
			wdog_clk_src_o     <= wsrc; // R10
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			osc_run_o  <= 1'b1;
			tick_run_o <= 1'b1;
			wdog_run_o <= 1'b1;
		end else begin
			osc_run_o  <= (st_r != CCS_ST_FULL); // R4
			tick_run_o <= ~in_stop | ((st_r == CCS_ST_PSEUDO) & pre_r & tsel_r); // R14
			wdog_run_o <= ~in_stop | // R15
			              ((st_r == CCS_ST_PSEUDO) & wlstop_r & (wsrc == CCS_WSRC_OSC)) |
			              ((wsrc == CCS_WSRC_ACLK) & ~wsdis_r); // R6
		end
	end

	// ----------------------------------------------------------------
	// Watchdog aux clock gate
	// ----------------------------------------------------------------
	// Stop is carried into the aux clock rate so the gate opens and closes
	// on aux edges only; the cost is a few aux cycles of lag each way
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wstop_r <= '0;
		end else if (aclk_en) begin
			wstop_r <= {wstop_r[WSTOP_SYN-2:0], in_stop}; // R7
		end
	end

	assign wgate = wsdis_r & wstop_r[WSTOP_SYN-1] & (wsrc == CCS_WSRC_ACLK); // R6 R7

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wdog_aclk_en_o <= 1'b0;
			atmr_aclk_en_o <= 1'b0;
		end else begin
			wdog_aclk_en_o <= aclk_en & ~wgate; // R6
			atmr_aclk_en_o <= aclk_en; // R9
		end
	end

	// ----------------------------------------------------------------
	// Oscillator loss on oscillator system clock
	// ----------------------------------------------------------------
	// A stall only clears by reset; the monitor reset avoids it
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			oscq_d_r <= 1'b0;
		end else begin
			oscq_d_r <= oscq;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stall_r             <= 1'b0;
			osc_monitor_reset_o <= 1'b0;
		end else begin
			osc_monitor_reset_o <= oscq_d_r & ~oscq & ~syspll_r &
			                       osc_monitor_reset_enable_i; // R21
			if (oscq_d_r & ~oscq & ~syspll_r & ~osc_monitor_reset_enable_i) begin
				stall_r <= 1'b1; // R21
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sys_stall_o <= 1'b0;
		end else begin
			sys_stall_o <= stall_r;
		end
	end

endmodule

//--- ccs_clk_sel_sva.sv
// Port-level assertions for the clock source select block
`timescale 1ns/1ns
module ccs_clk_sel_sva
	import ccs_pkg::*;
(
	input wire logic      core_clk_i,
	input wire logic      nrst_i,
	input wire logic      psel_i,
	input wire logic      penable_i,
	input wire logic      pready_o,
	input wire logic      pslverr_o,
	input wire logic      osc_qualified_i,
	input wire logic      stop_req_i,
	input wire logic      sys_clk_pll_sel_o,
	input wire logic      osc_run_o,
	input wire logic      tick_clk_osc_sel_o,
	input wire logic      tick_restart_o,
	input wire ccs_wsrc_t wdog_clk_src_o,
	input wire logic      wdog_restart_o,
	input wire logic      wdog_aclk_en_o,
	input wire logic      atmr_aclk_en_o,
	input wire logic      sys_stall_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);

	// ----------------------------------------------------------------
	// Aux tick spacing counter
	// ----------------------------------------------------------------
	logic [4:0] aux_gap_r;
	logic       aux_seen_r;
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aux_gap_r  <= 5'h00;
			aux_seen_r <= 1'b0;
		end else begin
			aux_gap_r  <= atmr_aclk_en_o ? 5'h00 : aux_gap_r + 5'h01;
			aux_seen_r <= aux_seen_r | atmr_aclk_en_o;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence setup_s;
		psel_i && !penable_i;
	endsequence
	sequence access_s;
		psel_i && penable_i;
	endsequence

	one_wait_a: assert property (setup_s ##1 access_s |=> pready_o)
		else $error("pready late");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("pready held");
	err_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("pslverr without pready");
	osc_loss_force_a: assert property (!osc_qualified_i [*6] |-> sys_clk_pll_sel_o
		&& !tick_clk_osc_sel_o && wdog_clk_src_o != CCS_WSRC_OSC)
		else $error("selects not forced");
	tick_restart_a: assert property (tick_restart_o == $changed(tick_clk_osc_sel_o))
		else $error("tick restart wrong");
	wdog_restart_a: assert property (wdog_restart_o == $changed(wdog_clk_src_o))
		else $error("watchdog restart wrong");
	atmr_free_a: assert property (aux_seen_r |-> atmr_aclk_en_o == (aux_gap_r == 5'd19))
		else $error("aux tick spacing");
	wdog_tick_a: assert property (wdog_aclk_en_o |-> atmr_aclk_en_o)
		else $error("watchdog tick off aux");
	stall_hold_a: assert property (sys_stall_o |=> sys_stall_o)
		else $error("stall dropped");
	osc_off_a: assert property (!osc_run_o |-> $past(stop_req_i, 2))
		else $error("oscillator off outside stop");
endmodule

bind ccs_clk_sel ccs_clk_sel_sva u_sva (
	.core_clk_i, .nrst_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .osc_qualified_i,
	.stop_req_i, .sys_clk_pll_sel_o, .osc_run_o, .tick_clk_osc_sel_o, .tick_restart_o,
	.wdog_clk_src_o, .wdog_restart_o, .wdog_aclk_en_o, .atmr_aclk_en_o, .sys_stall_o
);

//--- tb_ccs_clk_sel.sv
// Self-checking bench for the clock source select block
`timescale 1ns/1ns
module tb_ccs_clk_sel
	import ccs_pkg::*;
;
	logic              core_clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [ADDR_W-1:0] paddr_i;
	logic [31:0]       pwdata_i, prdata_o, rd;
	logic              osc_qualified_i, stop_req_i, special_mode_i, wdog_ctrl_written_i;
	logic              osc_monitor_reset_enable_i, sys_clk_pll_sel_o, osc_run_o, tick_run_o;
	logic              tick_clk_osc_sel_o, tick_restart_o, wdog_run_o, wdog_restart_o;
	logic              wdog_aclk_en_o, atmr_aclk_en_o, osc_monitor_reset_o, sys_stall_o, err_s;
	ccs_wsrc_t         wdog_clk_src_o;
	int                err_total, total_checks, cyc, n_trs, n_wrs, n_atm, n_wda, n_mon;
	int                css, locked, wprot, q, e_trs, e_wrs, e_mon;
	int                stv[4] = '{8'h4F, 8'h46, 8'h4B, 8'h0F};

	ccs_clk_sel uut (
		.core_clk_i, .nrst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .osc_qualified_i, .stop_req_i, .special_mode_i,
		.wdog_ctrl_written_i, .osc_monitor_reset_enable_i, .sys_clk_pll_sel_o, .osc_run_o,
		.tick_clk_osc_sel_o, .tick_run_o, .tick_restart_o, .wdog_clk_src_o, .wdog_run_o,
		.wdog_restart_o, .wdog_aclk_en_o, .atmr_aclk_en_o, .osc_monitor_reset_o, .sys_stall_o
	);

	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end

	// ----------------------------------------------------------------
	// Pulse counters and run limit
	// ----------------------------------------------------------------
	always @(posedge core_clk_i) begin
		cyc++;
		n_trs += tick_restart_o;
		n_wrs += wdog_restart_o;
		n_atm += atmr_aclk_en_o;
		n_wda += wdog_aclk_en_o;
		n_mon += osc_monitor_reset_o;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Model and bus tasks
	// ----------------------------------------------------------------
	function automatic int wsrc_of(input int c);
		return c[4] ? 2 : c[0];
	endfunction

	// Forced values are applied by the model at once, so restart counts include them
	task automatic set_css(input int nv);
		if (nv[1] != css[1]) e_trs++;
		if (wsrc_of(nv) != wsrc_of(css)) e_wrs++;
		css = nv;
	endtask

	function automatic int wr_model(input int d);
		int n;
		n = d & 255;
		if (wprot) return css;
		if (!q) n = (n | 128) & ~3;
		if (locked) n = (n & ~8'h31) | (css & 8'h31);
		return n;
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Waits for pready with no cycle limit; only the run limit ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge core_clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err_s = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input int e);
		apb(1'b0, a, 32'h0);
		chk("prdata", rd, e);
	endtask

	task automatic wcss(input int d);
		apb(1'b1, CSS_OFS, d);
		set_css(wr_model(d));
		rchk(CSS_OFS, css);
		chk("pll_sel", sys_clk_pll_sel_o, css[7]);
		chk("tick_sel", tick_clk_osc_sel_o, css[1]);
		chk("wdog_src", wdog_clk_src_o, wsrc_of(css));
	endtask

	task automatic setq(input logic v);
		if (!v && q && !css[7]) e_mon += osc_monitor_reset_enable_i;
		osc_qualified_i <= v;
		repeat (5) @(posedge core_clk_i);
		q = v;
		if (!v) set_css((css | 128) & ~3);
	endtask

	task automatic do_reset();
		nrst_i <= 1'b0;
		repeat (8) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		css = CSS_RST;
		locked = 0;
	endtask

	// Settle time covers the worst gate lag of four aux periods
	task automatic aux_win(input int e);
		int a0;
		int w0;
		repeat (100) @(posedge core_clk_i);
		a0 = n_atm;
		w0 = n_wda;
		repeat (200) @(posedge core_clk_i);
		chk("atmr_ticks", n_atm - a0, 10);
		chk("wdog_ticks", n_wda - w0, e);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		{nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		{osc_qualified_i, stop_req_i, special_mode_i, wdog_ctrl_written_i} = '0;
		osc_monitor_reset_enable_i = 1'b1;
		rd = $urandom(37);
		do_reset();
		rchk(CSS_OFS, CSS_RST);
		apb(1'b0, 8'h0C, 32'h0);
		chk("pslverr", err_s, 1'b1);
		wcss(8'h7F);
		setq(1'b1);
		wprot = 1;
		apb(1'b1, WPROT_OFS, 32'h1);
		wcss(8'h03);
		wprot = 0;
		apb(1'b1, WPROT_OFS, 32'h0);
		for (int i = 0; i < 24; i++) begin
			if (i % 4 == 0) setq($urandom % 4 != 0);
			wcss($urandom);
		end
		setq(1'b1);
		foreach (stv[i]) begin
			wcss(stv[i]);
			stop_req_i <= 1'b1;
			repeat (4) @(posedge core_clk_i);
			chk("osc_run", osc_run_o, css[6]);
			chk("tick_run", tick_run_o, css[6] & css[3] & css[1]);
			chk("wdog_run", wdog_run_o, css[6] & css[2] & css[0]);
			if (!css[6]) set_css((css | 128) & ~3);
			stop_req_i <= 1'b0;
			repeat (40) @(posedge core_clk_i);
			rchk(CSS_OFS, css);
		end
		wcss(8'hF0);
		stop_req_i <= 1'b1;
		aux_win(0);
		stop_req_i <= 1'b0;
		aux_win(10);
		wcss(8'hD0);
		stop_req_i <= 1'b1;
		aux_win(10);
		stop_req_i <= 1'b0;
		osc_monitor_reset_enable_i <= 1'b0;
		wcss(8'h00);
		setq(1'b0);
		chk("stall", sys_stall_o, 1'b1);
		special_mode_i <= 1'b1;
		wdog_ctrl_written_i <= 1'b1;
		@(posedge core_clk_i);
		wdog_ctrl_written_i <= 1'b0;
		wcss(8'h31);
		special_mode_i <= 1'b0;
		setq(1'b1);
		do_reset();
		wcss(8'h00);
		wdog_ctrl_written_i <= 1'b1;
		@(posedge core_clk_i);
		wdog_ctrl_written_i <= 1'b0;
		locked = 1;
		wcss(8'h3F);
		rchk(STAT_OFS, 8'h09);
		chk("tick_restarts", n_trs, e_trs);
		chk("wdog_restarts", n_wrs, e_wrs);
		chk("monitor_resets", n_mon, e_mon);
		tally_and_finish();
	end
endmodule
